// ===== icache_pkg.sv
// constants and types shared by the instruction cache
// assumes one 10 MHz core clock and a same-clock memory fetch path
package icache_pkg;
  // ========================================================
  // organisation
  localparam int unsigned LINE_COUNT = 512;
  localparam int unsigned WORD_COUNT = 2048;
  localparam int unsigned BEAT_COUNT = 4;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned INDEX_W = 9;
  localparam int unsigned WORD_IDX_W = 11;
  localparam int unsigned TAG_W = 20;
  localparam int unsigned LINE_ADDR_W = 28;
  // ========================================================
  // address fields
  localparam int unsigned INDEX_LSB = 4;
  localparam int unsigned INDEX_MSB = 12;
  localparam int unsigned WSEL_LSB = 2;
  localparam int unsigned WSEL_MSB = 12;
  localparam int unsigned TAG_LSB = 12;
  localparam int unsigned TAG_MSB = 31;
  localparam int unsigned BEAT_LSB = 2;
  localparam int unsigned BEAT_MSB = 3;
  // ========================================================
  // control and timing
  localparam int unsigned INVAL_CTRL_BIT = 24;
  localparam int unsigned INVAL_CYCLES = 512;
  localparam logic [8:0] INVAL_LAST = 9'(INVAL_CYCLES - 1);
  localparam logic [1:0] BEAT_LAST = 2'(BEAT_COUNT - 1);
  localparam logic [3:0] BUF_VALID_RST = 4'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  typedef enum logic [1:0] {ST_IDLE, ST_INVAL, ST_FILL} cache_state_t;
endpackage

// ===== direct_mapped_instruction_cache.sv
// direct mapped instruction cache with a line fill buffer
// assumes the core holds a fetch until acknowledged and memory returns
// the four beats of a line in wrap order on the same clock
`timescale 1ns/1ps

module direct_mapped_instruction_cache
(
  input wire logic clk,
  input wire logic reset,
  input wire logic fetch_req,
  input wire logic [icache_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic sram_sel,
  input wire logic invalidate_all,
  output logic fetch_ack,
  output logic [icache_pkg::DATA_W-1:0] fetch_rdata,
  output logic inval_busy,
  output logic mem_req,
  output logic [icache_pkg::ADDR_W-1:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic [icache_pkg::DATA_W-1:0] mem_rdata
);
  import icache_pkg::*;

  // ========================================================
  // storage
  // arrays keep their contents through reset; software invalidates first
  logic [TAG_W-1:0] tag_q [LINE_COUNT];
  logic valid_q [LINE_COUNT];
  logic [DATA_W-1:0] data_q [WORD_COUNT];
  logic [DATA_W-1:0] buf_data_q [BEAT_COUNT];
  logic [3:0] buf_valid_q;
  logic [LINE_ADDR_W-1:0] buf_line_q;
  logic buf_mru_q;
  cache_state_t state_q;
  logic [8:0] inval_cnt_q;
  logic inval_pend_q;
  logic pending_q;
  logic [1:0] beat_cnt_q;
  logic [1:0] crit_q;
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic mem_req_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic inval_busy_q;

  function automatic logic [INDEX_W-1:0] line_index(input logic [ADDR_W-1:0] a);
    line_index = a[INDEX_MSB:INDEX_LSB];
  endfunction

  // ========================================================
  // lookup
  logic [INDEX_W-1:0] idx;
  logic [WORD_IDX_W-1:0] widx;
  logic [1:0] beat;
  logic lookup;
  logic arr_hit;
  logic buf_hit;
  logic miss_start;
  logic writeback;
  logic [INDEX_W-1:0] buf_idx;
  logic [TAG_W-1:0] buf_tag;
  logic [1:0] fill_beat;
  logic [DATA_W-1:0] hit_data;

  assign idx = line_index(fetch_addr);
  assign widx = fetch_addr[WSEL_MSB:WSEL_LSB];
  assign beat = fetch_addr[BEAT_MSB:BEAT_LSB];
  assign buf_idx = buf_line_q[INDEX_W-1:0];
  // bit 12 is shared by index and tag, so the tag starts inside the index
  assign buf_tag = buf_line_q[LINE_ADDR_W-1:TAG_LSB-INDEX_LSB];
  assign lookup = fetch_req && !sram_sel && !pending_q && state_q != ST_INVAL;
  assign arr_hit = valid_q[idx] && tag_q[idx] == fetch_addr[TAG_MSB:TAG_LSB];
  assign buf_hit = buf_line_q == fetch_addr[ADDR_W-1:INDEX_LSB] && buf_valid_q[beat];
  // one fill at a time: a miss during a fill stalls until it ends
  // a miss in the cycle of an invalidate pulse waits, invalidate goes first
  assign miss_start = lookup && !arr_hit && !buf_hit && state_q == ST_IDLE && !inval_pend_q && !invalidate_all;
  assign writeback = miss_start && (&buf_valid_q) && buf_mru_q;
  assign fill_beat = crit_q + beat_cnt_q;
  assign hit_data = buf_hit ? buf_data_q[beat] : data_q[widx];

  // ========================================================
  // control
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      inval_cnt_q <= '0;
      inval_pend_q <= 1'b0;
      beat_cnt_q <= '0;
      inval_busy_q <= 1'b0;
    end
    else
    begin
      if (invalidate_all)
        inval_pend_q <= 1'b1;
      case (state_q)
        ST_IDLE:
        begin
          if (inval_pend_q || invalidate_all)
          begin
            state_q <= ST_INVAL;
            inval_busy_q <= 1'b1;
            inval_cnt_q <= '0;
            inval_pend_q <= 1'b0;
          end
          else if (miss_start)
          begin
            state_q <= ST_FILL;
            beat_cnt_q <= '0;
          end
        end
        ST_INVAL:
        begin
          inval_cnt_q <= inval_cnt_q + 9'h001;
          if (inval_cnt_q == INVAL_LAST)
          begin
            state_q <= ST_IDLE;
            inval_busy_q <= 1'b0;
          end
        end
        ST_FILL:
        begin
          if (mem_rvalid)
          begin
            beat_cnt_q <= beat_cnt_q + 2'h1;
            if (beat_cnt_q == BEAT_LAST)
              state_q <= ST_IDLE;
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
          inval_busy_q <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================
  // tag array
  always_ff @(posedge clk)
  begin
    if (state_q == ST_INVAL)
      valid_q[inval_cnt_q] <= 1'b0;
    else if (writeback)
    begin
      tag_q[buf_idx] <= buf_tag;
      valid_q[buf_idx] <= 1'b1;
    end
  end

  // ========================================================
  // data array
  // whole line written in one cycle so a partial line never lands
  always_ff @(posedge clk)
  begin
    if (writeback)
    begin
      for (int i = 0; i < BEAT_COUNT; i++)
        data_q[{buf_idx, 2'(i)}] <= buf_data_q[i];
    end
  end

  // ========================================================
  // fill buffer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      buf_valid_q <= BUF_VALID_RST;
      buf_line_q <= '0;
      buf_mru_q <= 1'b0;
      crit_q <= '0;
    end
    else if (state_q == ST_IDLE && (inval_pend_q || invalidate_all))
      buf_valid_q <= BUF_VALID_RST;
    else if (miss_start)
    begin
      buf_valid_q <= BUF_VALID_RST;
      buf_line_q <= fetch_addr[ADDR_W-1:INDEX_LSB];
      crit_q <= beat;
      buf_mru_q <= 1'b1;
    end
    else
    begin
      if (state_q == ST_FILL && mem_rvalid)
        buf_valid_q[fill_beat] <= 1'b1;
      if (lookup && arr_hit && !buf_hit && idx == buf_idx)
        buf_mru_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (state_q == ST_FILL && mem_rvalid)
      buf_data_q[fill_beat] <= mem_rdata;
  end

  // ========================================================
  // external fetch
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem_req_q <= 1'b0;
      mem_addr_q <= '0;
    end
    else
    begin
      mem_req_q <= miss_start;
      if (miss_start)
        mem_addr_q <= {fetch_addr[ADDR_W-1:BEAT_LSB], 2'h0};
    end
  end

  // ========================================================
  // answer to the core
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
      rdata_q <= RDATA_RST;
      pending_q <= 1'b0;
    end
    else
    begin
      ack_q <= 1'b0;
      if (miss_start)
        pending_q <= 1'b1;
      if (pending_q && state_q == ST_FILL && mem_rvalid && beat_cnt_q == 2'h0)
      begin
        ack_q <= 1'b1;
        rdata_q <= mem_rdata;
        pending_q <= 1'b0;
      end
      else if (lookup && (arr_hit || buf_hit))
      begin
        ack_q <= 1'b1;
        rdata_q <= hit_data;
      end
    end
  end

  assign fetch_ack = ack_q;
  assign fetch_rdata = rdata_q;
  assign inval_busy = inval_busy_q;
  assign mem_req = mem_req_q;
  assign mem_addr = mem_addr_q;

  // ========================================================
  // checks
  sequence s_inval_last;
    state_q == ST_INVAL && inval_cnt_q == INVAL_LAST;
  endsequence
  sequence s_hit;
    lookup && (arr_hit || buf_hit) && !pending_q;
  endsequence
  sequence s_first_beat;
    pending_q && state_q == ST_FILL && mem_rvalid && beat_cnt_q == 2'h0;
  endsequence

  property p_inval_end;
    @(posedge clk) disable iff (reset) s_inval_last |=> state_q == ST_IDLE;
  endproperty
  a_inval_end: assert property (p_inval_end) else $error("invalidate did not end at 512");

  property p_inval_hold;
    @(posedge clk) disable iff (reset)
      (state_q == ST_INVAL && inval_cnt_q != INVAL_LAST) |=> state_q == ST_INVAL && inval_cnt_q == $past(inval_cnt_q) + 9'h001;
  endproperty
  a_inval_hold: assert property (p_inval_hold) else $error("invalidate ended early");

  property p_inval_stall;
    @(posedge clk) disable iff (reset) (state_q == ST_INVAL) [*2] |-> !fetch_ack;
  endproperty
  a_inval_stall: assert property (p_inval_stall) else $error("fetch answered during invalidate");

  property p_hit_answer;
    @(posedge clk) disable iff (reset) s_hit |=> fetch_ack && fetch_rdata == $past(hit_data);
  endproperty
  a_hit_answer: assert property (p_hit_answer) else $error("hit not answered next cycle");

  property p_miss_fetch;
    @(posedge clk) disable iff (reset)
      miss_start |=> mem_req && mem_addr == {$past(fetch_addr[31:2]), 2'h0} ##1 !mem_req;
  endproperty
  a_miss_fetch: assert property (p_miss_fetch) else $error("miss fetch request wrong");

  property p_first_beat;
    @(posedge clk) disable iff (reset) s_first_beat |=> fetch_ack && fetch_rdata == $past(mem_rdata) && !pending_q;
  endproperty
  a_first_beat: assert property (p_first_beat) else $error("critical word not passed on");

  property p_sram;
    @(posedge clk) disable iff (reset) (fetch_req && sram_sel && !pending_q) |=> !fetch_ack && !mem_req;
  endproperty
  a_sram: assert property (p_sram) else $error("cache acted on sram fetch");

  property p_buf_clear;
    @(posedge clk) disable iff (reset) mem_req |-> buf_valid_q == BUF_VALID_RST && state_q == ST_FILL;
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("buffer valids not cleared");

  property p_wrap;
    @(posedge clk) disable iff (reset) (state_q == ST_FILL && mem_rvalid) |=> buf_valid_q[$past(fill_beat)];
  endproperty
  a_wrap: assert property (p_wrap) else $error("beat not marked valid");

  property p_writeback;
    @(posedge clk) disable iff (reset)
      writeback |-> buf_valid_q == 4'hF && buf_mru_q
        ##1 valid_q[$past(buf_idx)] && tag_q[$past(buf_idx)] == $past(buf_tag);
  endproperty
  a_writeback: assert property (p_writeback) else $error("partial or stale line written");
endmodule

// ===== mem_model.sv
// behavioural external memory for the instruction cache fetch path
// assumes the cache clock and one line burst outstanding at a time
`timescale 1ns/1ps
module mem_model
#(
  parameter int GAP = 3
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  // ========================================
  // burst responder
  logic [31:0] base_q;
  logic [1:0] beat_q;
  logic active_q;
  int wait_q;
  // idle data toggles so stale beats never look valid
  always @(posedge clk)
  begin
    mem_rvalid <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (reset)
    begin
      active_q <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end
    else if (mem_req)
    begin
      base_q <= mem_addr;
      beat_q <= 2'h0;
      wait_q <= GAP;
      active_q <= 1'b1;
    end
    else if (active_q && wait_q != 0)
      wait_q <= wait_q - 1;
    else if (active_q)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata <= {base_q[31:4], base_q[3:2] + beat_q, 2'h0} ^ 32'h5A5A_0000;
      beat_q <= beat_q + 2'h1;
      active_q <= (beat_q != 2'h3);
    end
  end
endmodule

// ===== direct_mapped_instruction_cache_test.sv
// self-checking bench for the direct mapped instruction cache
// assumes mem_model returns word data as address xor a fixed pattern
`timescale 1ns/1ps
module direct_mapped_instruction_cache_test;
  import icache_pkg::*;
  logic clk, reset, fetch_req, sram_sel, invalidate_all, fetch_ack, inval_busy, mem_req, mem_rvalid;
  logic [31:0] fetch_addr, fetch_rdata, mem_addr, mem_rdata;
  int num_errors = 0;
  int comparisons = 0;
  direct_mapped_instruction_cache uut (.clk(clk), .reset(reset), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .sram_sel(sram_sel), .invalidate_all(invalidate_all), .fetch_ack(fetch_ack),
    .fetch_rdata(fetch_rdata), .inval_busy(inval_busy), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  mem_model #(.GAP(3)) mem (.clk(clk), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // ========================================
  // checking
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ========================================
  // scenarios
  // hit: dropped at the taking edge; miss: dropped when the first beat is seen
  task automatic fetch(input logic [31:0] a, input bit hit);
    logic seen;
    int n;
    logic [31:0] next_addr;
    seen = 1'b0;
    next_addr = {a[31:4], a[3:2] + 2'h1, 2'h0};
    n = 0;
    fetch_addr <= a;
    fetch_req <= 1'b1;
    @(posedge clk);
    while (!hit && mem_rvalid !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
      if (mem_req === 1'b1)
      begin
        seen = 1'b1;
        chk(mem_addr, {a[31:2], 2'h0});
      end
    end
    fetch_req <= 1'b0;
    @(posedge clk);
    seen = seen | (mem_req === 1'b1);
    chk(fetch_ack, 32'h1);
    chk(fetch_rdata, a ^ 32'h5A5A_0000);
    chk(seen, !hit);
    // second beat has arrived, rest of the line still in flight
    if (!hit)
    begin
      fetch_addr <= next_addr;
      fetch_req <= 1'b1;
      @(posedge clk);
      fetch_req <= 1'b0;
      @(posedge clk);
      chk(fetch_ack, 32'h1);
      chk(fetch_rdata, next_addr ^ 32'h5A5A_0000);
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic inval();
    int n;
    n = 0;
    invalidate_all <= 1'b1;
    @(posedge clk);
    invalidate_all <= 1'b0;
    @(posedge clk);
    while (inval_busy === 1'b1 && n < 600)
    begin
      n++;
      @(posedge clk);
    end
    chk(n, 32'd512);
  endtask
  task automatic sram_fetch();
    fetch_addr <= 32'h0000_5000;
    sram_sel <= 1'b1;
    fetch_req <= 1'b1;
    repeat (4)
    begin
      @(posedge clk);
      chk(fetch_ack | mem_req, 32'h0);
    end
    fetch_req <= 1'b0;
    sram_sel <= 1'b0;
    @(posedge clk);
  endtask
  // ========================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #(5000 * 100);
    num_errors++;
    end_sim();
  end
  initial
  begin
    reset = 1'b1;
    fetch_req = 1'b0;
    fetch_addr = 32'h0000_0000;
    sram_sel = 1'b0;
    invalidate_all = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({fetch_ack, mem_req, inval_busy}, 32'h0);
    chk(fetch_rdata, 32'h0);
    inval();
    fetch(32'h0000_1238, 1'b0);
    for (int k = 0; k < 4; k++)
      fetch(32'h0000_1230 + 32'(4 * k), 1'b1);
    fetch(32'h0000_3234, 1'b0);
    fetch(32'h0000_123C, 1'b1);
    fetch(32'h0000_1000, 1'b0);
    fetch(32'h0000_3230, 1'b0);
    sram_fetch();
    fetch(32'h0000_3238, 1'b1);
    inval();
    fetch(32'h0000_1234, 1'b0);
    end_sim();
  end
endmodule
